/* File: core/switch_homing_axis.sv */
// Notes on behaviour
// RL1: Mode 02h plus start reports code 0001
// RL2: Continuous feed only while jog switch on
// RL3: Mode 56h counts move amount down, stops
// RL4: Switch changes ignored once move started
// RL5: Zero move amount ends with no pulses
// RL6: Limit in 56h stops, raises error output
// RL7: Decode homing, leave and search codes
// RL8: Origin polarity bit; sub-status bit 14
// RL9: Index edge select; status bit 10
// RL10: Index count field is pulses minus one
// RL11: Strap pin sets limit input polarity
// RL12: Limit bit 3 picks immediate or ramp
// RL13: Limit states in sub-status bits 12, 13
// RL14: Filter bit 26 drops pulses under 4us
// RL15: Homing completion clears counter, clear pulse
// RL16: Method 0 stops on origin on
// RL17: Method 1 back off, return, stop
// RL18: Method 2 counts index, ramps meanwhile
// RL19: Method 3 counts index then stops
// RL20: Method 4 reverses, counts index after off
// RL21: Method 5 reverses at start speed, counts
// RL22: Method 6 uses limit, stops on off
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "switch_homing_defines.svh"
module switch_homing_axis
	import switch_homing_pkg::*;
#(
	parameter int POS_WIDTH = 28
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// AXI4-Lite slave
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Machine side inputs
	input wire logic jogPlusSwitch,
	input wire logic jogMinusSwitch,
	input wire logic switchGate_n,
	input wire logic endLimitPlus,
	input wire logic endLimitMinus,
	input wire logic originSensor,
	input wire logic encoderIndex,
	input wire logic limitLogicStrap,
	// Machine side outputs
	output logic pulseOut,
	output logic dirOut,
	output logic deviationClearOut,
	output logic errorIrq
);
	localparam int FILT_CYC = (`FILTER_TIME_NS + `CLK_PERIOD_NS - 1) /
		`CLK_PERIOD_NS;
	localparam int CLR_CYC = (`CLEAR_PULSE_TIME_NS + `CLK_PERIOD_NS - 1) /
		`CLK_PERIOD_NS;
	localparam logic [5:0] FILT_LAST = 6'(FILT_CYC - 1);
	localparam logic [5:0] CLR_LAST = 6'(CLR_CYC - 1);

	if (POS_WIDTH < 8 || POS_WIDTH > 32) begin : gBadWidth
		$error("POS_WIDTH must lie in 8..32");
	end

	function automatic logic isMapped(input logic [7:0] a);
		isMapped = (a[1:0] == 2'b00) && (a <= `REG_COUNTER_ONE);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	logic [7:0] awAddr_ff;
	logic [31:0] wData_ff;
	logic [3:0] wStrb_ff;
	logic awFull_ff, wFull_ff, doWrite, wrOk;
	logic [6:0] opSelect_ff;
	logic [31:0] moveAmount_ff, envOne_ff, envTwo_ff, envHoming_ff;
	logic [15:0] startPeriod_ff, topPeriod_ff, approachPeriod_ff;
	logic cmdStb;
	logic [7:0] cmdCode;
	logic [15:0] subStatus;
	logic [31:0] extStatus;
	logic [31:0] counterOne_ff;

	assign awready = !awFull_ff && !bvalid;
	assign wready = !wFull_ff && !bvalid;
	assign doWrite = awFull_ff && wFull_ff && !bvalid;
	assign wrOk = isMapped(awAddr_ff);
	assign cmdStb = doWrite && awAddr_ff == `REG_COMMAND && wStrb_ff[0];
	assign cmdCode = wData_ff[7:0];
	assign arready = !rvalid;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			awFull_ff <= 1'b0;
			wFull_ff <= 1'b0;
			bvalid <= 1'b0;
			bresp <= 2'b00;
			awAddr_ff <= 8'h00;
			wData_ff <= `RST_ZERO32;
			wStrb_ff <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				awAddr_ff <= awaddr;
				awFull_ff <= 1'b1;
			end
			if (wvalid && wready) begin
				wData_ff <= wdata;
				wStrb_ff <= wstrb;
				wFull_ff <= 1'b1;
			end
			if (doWrite) begin
				awFull_ff <= 1'b0;
				wFull_ff <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wrOk ? 2'b00 : 2'b10;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			opSelect_ff <= 7'h00;
			moveAmount_ff <= `RST_ZERO32;
			envOne_ff <= `RST_ZERO32;
			envTwo_ff <= `RST_ZERO32;
			envHoming_ff <= `RST_ZERO32;
			startPeriod_ff <= `RST_START_PERIOD;
			topPeriod_ff <= `RST_TOP_PERIOD;
			approachPeriod_ff <= `RST_APPROACH_PERIOD;
		end else if (doWrite) begin
			case (awAddr_ff)
				`REG_OP_SELECT: begin
					if (wStrb_ff[0])
						opSelect_ff <= wData_ff[6:0];
				end
				`REG_MOVE_AMOUNT:
					moveAmount_ff <= merge(moveAmount_ff, wData_ff, wStrb_ff);
				`REG_ENV_ONE: envOne_ff <= merge(envOne_ff, wData_ff, wStrb_ff);
				`REG_ENV_TWO: envTwo_ff <= merge(envTwo_ff, wData_ff, wStrb_ff);
				`REG_ENV_HOMING:
					envHoming_ff <= merge(envHoming_ff, wData_ff, wStrb_ff);
				`REG_START_SPEED: startPeriod_ff <= wData_ff[15:0];
				`REG_TOP_SPEED: topPeriod_ff <= wData_ff[15:0];
				`REG_APPROACH_SPEED: approachPeriod_ff <= wData_ff[15:0];
				default: ;
			endcase
		end
	end

	// Settings registers are write-only and read back as zero
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rvalid <= 1'b0;
			rdata <= `RST_ZERO32;
			rresp <= 2'b00;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp <= isMapped(araddr) ? 2'b00 : 2'b10;
			case (araddr)
				`REG_SUB_STATUS: rdata <= {16'h0000, subStatus};
				`REG_EXT_STATUS: rdata <= extStatus;
				`REG_COUNTER_ONE: rdata <= counterOne_ff;
				default: rdata <= `RST_ZERO32;
			endcase
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Sensor polarity and glitch filter
	logic limitNegLogic_ff;
	logic [2:0] rawAct, filt_ff;
	sensor_s sens, sensPrev_ff;
	logic filterOn;

	assign filterOn = envOne_ff[`ENV1_SENSOR_FILTER];
	assign rawAct[0] = limitNegLogic_ff ? !endLimitPlus : endLimitPlus; // [RL11]
	assign rawAct[1] = limitNegLogic_ff ? !endLimitMinus : endLimitMinus;
	assign rawAct[2] = envOne_ff[`ENV1_ORIGIN_LOGIC] ? originSensor :
		!originSensor; // [RL8]
	assign sens = sensor_s'(filt_ff);

	// Strap is re-sampled each cycle so it is never loaded under reset
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			limitNegLogic_ff <= 1'b0;
		else
			limitNegLogic_ff <= limitLogicStrap; // [RL11]
	end

	for (genvar g = 0; g < 3; g++) begin : gFilt
		logic [5:0] cnt_ff;
		always_ff @(posedge core_clk) begin
			if (!rst_n) begin
				cnt_ff <= 6'h00;
				filt_ff[g] <= 1'b0;
			end else if (!filterOn || rawAct[g] == filt_ff[g]) begin
				cnt_ff <= 6'h00;
				filt_ff[g] <= rawAct[g];
			end else if (cnt_ff == FILT_LAST) begin
				cnt_ff <= 6'h00;
				filt_ff[g] <= rawAct[g]; // [RL14]
			end else begin
				cnt_ff <= cnt_ff + 6'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	axis_state_e state_ff;
	op_kind_e kind_ff;
	after_brake_e after_ff;
	logic dir_ff, high_ff, accel_ff, decel_ff, counting_ff, watch_ff;
	logic doneStb_ff, clrStb_ff, indexPrev_ff;
	logic [3:0] idxCnt_ff, method, idxTarget;
	logic [15:0] curPeriod_ff, periodCnt_ff;
	logic [POS_WIDTH-1:0] posCnt_ff;
	logic moving, tick, swPlus, swMinus, swDir, limAct, idxEdge, idxDone;
	logic orgRise, orgFall, watchFall, elm, startCmd, stopCmd;
	axis_state_e stopTarget;
	op_kind_e newKind;

	assign method = envHoming_ff[`ENV3_METHOD_LSB +: 4];
	assign idxTarget = envHoming_ff[`ENV3_INDEX_COUNT_LSB +: 4];
	assign elm = envOne_ff[`ENV1_LIMIT_DECEL];
	assign swPlus = envOne_ff[`ENV1_SWITCH_LOGIC] ? jogPlusSwitch :
		!jogPlusSwitch;
	assign swMinus = envOne_ff[`ENV1_SWITCH_LOGIC] ? jogMinusSwitch :
		!jogMinusSwitch;
	assign swDir = !switchGate_n && (dir_ff ? swMinus : swPlus);
	assign limAct = dir_ff ? sens.limitMinus : sens.limitPlus;
	assign orgRise = sens.origin && !sensPrev_ff.origin;
	assign orgFall = !sens.origin && sensPrev_ff.origin;
	assign watchFall = watch_ff ? (!sens.limitMinus && sensPrev_ff.limitMinus)
		: (!sens.limitPlus && sensPrev_ff.limitPlus);
	assign idxEdge = envTwo_ff[`ENV2_INDEX_EDGE] ?
		(encoderIndex && !indexPrev_ff) :
		(!encoderIndex && indexPrev_ff); // [RL9]
	assign idxDone = counting_ff && idxEdge && idxCnt_ff == idxTarget; // [RL10]
	assign moving = state_ff == S_FEED || state_ff == S_BRAKE ||
		state_ff == S_BACK || state_ff == S_RETURN;
	assign tick = moving && (periodCnt_ff + 16'h0001 >= curPeriod_ff);
	assign startCmd = cmdStb && cmdCode[7:2] == `CMD_START_BASE;
	assign stopCmd = cmdStb && cmdCode == `CMD_IMMEDIATE_STOP;
	assign stopTarget = (kind_ff == K_CONT) ? S_WAITSW : S_IDLE;

	always_comb begin
		case (opSelect_ff) // [RL7]
			`OP_SWITCH_CONT: newKind = K_CONT;
			`OP_SWITCH_POS: newKind = K_SWPOS;
			`OP_HOME_POS, `OP_HOME_NEG, `OP_SEARCH_POS, `OP_SEARCH_NEG,
			`OP_LEAVE_POS, `OP_LEAVE_NEG: newKind = K_HOME;
			default: newKind = K_NONE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n || !moving || tick)
			periodCnt_ff <= 16'h0000;
		else
			periodCnt_ff <= periodCnt_ff + 16'h0001;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sensPrev_ff <= '0;
			indexPrev_ff <= 1'b0;
		end else begin
			sensPrev_ff <= sens;
			indexPrev_ff <= encoderIndex;
		end
	end

	// Axis sequencer; leaving zero reuses the homing kind with leaveMode
	logic leaveMode_ff;
	always_ff @(posedge core_clk) begin
		logic goBack, finish;
		goBack = 1'b0;
		finish = 1'b0;
		if (!rst_n) begin
			state_ff <= S_IDLE;
			kind_ff <= K_NONE;
			after_ff <= A_STOP;
			{dir_ff, high_ff, accel_ff, decel_ff} <= 4'h0;
			{counting_ff, watch_ff, leaveMode_ff} <= 3'h0;
			{doneStb_ff, clrStb_ff, errorIrq} <= 3'h0;
			idxCnt_ff <= 4'h0;
			curPeriod_ff <= `RST_START_PERIOD;
			posCnt_ff <= '0;
		end else begin
			doneStb_ff <= 1'b0;
			clrStb_ff <= 1'b0;
			if (counting_ff && idxEdge)
				idxCnt_ff <= idxCnt_ff + 4'h1;
			if (tick) begin
				if (state_ff == S_BRAKE || decel_ff) begin
					if (curPeriod_ff < startPeriod_ff)
						curPeriod_ff <= curPeriod_ff + 16'h0001;
				end else if (accel_ff && curPeriod_ff > topPeriod_ff) begin
					curPeriod_ff <= curPeriod_ff - 16'h0001;
				end
			end
			if (stopCmd || startCmd)
				errorIrq <= 1'b0;
			if (stopCmd) begin
				state_ff <= S_IDLE;
			end else if (startCmd && state_ff == S_IDLE) begin
				kind_ff <= newKind;
				high_ff <= cmdCode[1];
				accel_ff <= cmdCode[1];
				decel_ff <= 1'b0;
				counting_ff <= 1'b0;
				idxCnt_ff <= 4'h0;
				dir_ff <= opSelect_ff[3];
				leaveMode_ff <= opSelect_ff[1] && !opSelect_ff[2];
				curPeriod_ff <= (cmdCode[0] && !cmdCode[1]) ? topPeriod_ff :
					startPeriod_ff;
				posCnt_ff <= moveAmount_ff[POS_WIDTH-1:0]; // [RL3]
				case (newKind)
					K_CONT: state_ff <= S_WAITSW; // [RL1]
					K_SWPOS: state_ff <= (moveAmount_ff[POS_WIDTH-1:0] == '0) ?
						S_IDLE : S_WAITSW; // [RL5]
					K_HOME: state_ff <= S_FEED;
					default: state_ff <= S_IDLE;
				endcase
			end else begin
				case (state_ff)
					S_WAITSW: begin
						if (!switchGate_n && swPlus && !sens.limitPlus) begin
							dir_ff <= 1'b0;
							state_ff <= S_FEED; // [RL2]
						end else if (!switchGate_n && swMinus &&
							!sens.limitMinus) begin
							dir_ff <= 1'b1;
							state_ff <= S_FEED;
						end
					end
					S_FEED: begin
						if (limAct && !(kind_ff == K_HOME && method == 4'h6)) begin
							if (kind_ff == K_SWPOS)
								errorIrq <= 1'b1; // [RL6]
							if (elm && high_ff) begin
								state_ff <= S_BRAKE; // [RL12]
								after_ff <= A_STOP;
							end else begin
								state_ff <= stopTarget; // [RL12]
							end
						end else if (kind_ff == K_CONT) begin
							if (!swDir && high_ff) begin
								state_ff <= S_BRAKE;
								after_ff <= A_STOP;
							end else if (!swDir) begin
								state_ff <= S_WAITSW; // [RL2]
							end
						end else if (kind_ff == K_SWPOS) begin
							// Switch is not looked at here once the move runs
							if (tick) begin
								posCnt_ff <= posCnt_ff - 1'b1; // [RL3] [RL4]
								if (posCnt_ff == POS_WIDTH'(1))
									state_ff <= S_IDLE;
							end
						end else if (leaveMode_ff) begin
							if (!sens.origin)
								state_ff <= S_IDLE;
						end else begin
							case (method)
								4'h0: begin
									if (orgRise) begin
										clrStb_ff <= 1'b1; // [RL16]
										if (high_ff) begin
											state_ff <= S_BRAKE;
											after_ff <= A_DONE;
										end else begin
											finish = 1'b1;
										end
									end
								end
								4'h1, 4'h4, 4'h5: begin
									if (orgRise && high_ff) begin
										state_ff <= S_BRAKE; // [RL17] [RL20]
										after_ff <= A_BACK;
									end else if (orgRise) begin
										goBack = 1'b1; // [RL21]
									end
								end
								4'h2, 4'h3: begin
									if (orgRise) begin
										counting_ff <= 1'b1; // [RL18] [RL19]
										decel_ff <= high_ff && method == 4'h2;
									end
									if (idxDone && high_ff && method == 4'h3) begin
										state_ff <= S_BRAKE; // [RL19]
										after_ff <= A_DONE;
									end else if (idxDone) begin
										finish = 1'b1; // [RL18]
									end
								end
								4'h6: begin
									if (limAct && high_ff && elm) begin
										state_ff <= S_BRAKE;
										after_ff <= A_BACK;
									end else if (limAct) begin
										goBack = 1'b1; // [RL22]
									end
								end
								default: state_ff <= S_IDLE;
							endcase
						end
					end
					S_BRAKE: begin
						if (tick && curPeriod_ff >= startPeriod_ff) begin
							case (after_ff)
								A_DONE: finish = 1'b1;
								A_BACK: goBack = 1'b1;
								default: state_ff <= stopTarget;
							endcase
						end
					end
					S_BACK: begin
						if (method == 4'h1 && orgFall) begin
							state_ff <= S_RETURN; // [RL17]
							dir_ff <= !dir_ff;
						end else if (method == 4'h6 && watchFall) begin
							finish = 1'b1; // [RL22]
						end else if (orgFall) begin
							counting_ff <= 1'b1; // [RL20] [RL21]
						end else if (idxDone && method == 4'h5 && high_ff) begin
							state_ff <= S_BRAKE;
							after_ff <= A_DONE;
						end else if (idxDone) begin
							finish = 1'b1;
						end
					end
					S_RETURN: begin
						if (orgRise)
							finish = 1'b1; // [RL17]
					end
					default: state_ff <= S_IDLE;
				endcase
			end
			if (goBack) begin
				state_ff <= S_BACK;
				watch_ff <= dir_ff;
				dir_ff <= !dir_ff;
				counting_ff <= 1'b0;
				decel_ff <= 1'b0;
				accel_ff <= method == 4'h5 && high_ff; // [RL21]
				curPeriod_ff <= (method == 4'h5) ? startPeriod_ff :
					approachPeriod_ff;
			end
			if (finish) begin
				state_ff <= S_IDLE;
				doneStb_ff <= 1'b1; // [RL15]
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs, counter and clear pulse
	logic [5:0] clrCnt_ff;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pulseOut <= 1'b0;
			dirOut <= 1'b0;
		end else begin
			pulseOut <= tick;
			dirOut <= dir_ff;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			counterOne_ff <= `RST_ZERO32;
		else if ((doneStb_ff || clrStb_ff) &&
			envHoming_ff[`ENV3_CLEAR_COUNTER_ONE])
			counterOne_ff <= `RST_ZERO32; // [RL15]
		else if (tick)
			counterOne_ff <= dir_ff ? counterOne_ff - 32'h1 :
				counterOne_ff + 32'h1;
	end

	// Fixed width pulse so a driver always sees a full clear
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			deviationClearOut <= 1'b0;
			clrCnt_ff <= 6'h00;
		end else if (doneStb_ff && envOne_ff[`ENV1_CLEAR_AUTO]) begin
			deviationClearOut <= 1'b1; // [RL15]
			clrCnt_ff <= 6'h00;
		end else if (deviationClearOut) begin
			clrCnt_ff <= clrCnt_ff + 6'h01;
			if (clrCnt_ff == CLR_LAST)
				deviationClearOut <= 1'b0;
		end
	end

	assign subStatus = {1'b0, sens.origin, sens.limitMinus, sens.limitPlus,
		12'h000}; // [RL8] [RL13]
	assign extStatus = {19'h00000, swMinus, swPlus, encoderIndex, 6'h00,
		state_ff == S_IDLE ? `CND_IDLE : state_ff == S_WAITSW ?
		`CND_WAIT_SWITCH : `CND_RUNNING}; // [RL1] [RL9]

	////////////////////////////////////////////////////////////////////
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	chk_wait_code: assert property (state_ff == S_WAITSW |-> // [RL1]
		extStatus[3:0] == 4'h1) else $error("wait code wrong");
	chk_switch_gate: assert property (state_ff == S_FEED && // [RL2]
		kind_ff == K_CONT && $past(state_ff) == S_FEED |->
		$past(swDir)) else $error("feed without switch");
	chk_pos_count: assert property (tick && // [RL3]
		kind_ff == K_SWPOS && state_ff == S_FEED &&
		!limAct && !stopCmd |=> posCnt_ff == $past(posCnt_ff) - 1'b1)
		else $error("no count");
	chk_zero_move: assert property (startCmd && // [RL5]
		state_ff == S_IDLE && newKind == K_SWPOS &&
		moveAmount_ff[POS_WIDTH-1:0] == '0 |=> state_ff == S_IDLE ##1
		!pulseOut[*3]) else $error("zero move ran");
	chk_limit_error: assert property (state_ff == S_FEED && // [RL6]
		kind_ff == K_SWPOS && limAct && !stopCmd |=> errorIrq)
		else $error("no error");
	// Compared with the pins, one cycle back, while no filter runs
	chk_origin_bit: assert property ($past(rst_n) && // [RL8]
		$past(!filterOn) |-> subStatus[14] ==
		$past(envOne_ff[`ENV1_ORIGIN_LOGIC] ~^ originSensor) &&
		subStatus[12] == $past(limitNegLogic_ff ^ endLimitPlus))
		else $error("status bits");
	chk_filter_hold: assert property (filterOn && // [RL14]
		$past(filterOn) && $changed(filt_ff[2]) |->
		$past(gFilt[2].cnt_ff) == FILT_LAST)
		else $error("short pulse passed");
	chk_clear_pulse: assert property (doneStb_ff && // [RL15]
		envOne_ff[`ENV1_CLEAR_AUTO] |=> deviationClearOut[*8])
		else $error("clear pulse short");
	chk_counter_reset: assert property (doneStb_ff && // [RL15]
		envHoming_ff[`ENV3_CLEAR_COUNTER_ONE] |=> counterOne_ff == '0)
		else $error("counter not cleared");
	chk_return_stop: assert property (state_ff == S_RETURN && // [RL17]
		orgRise && !stopCmd |=> state_ff == S_IDLE)
		else $error("no stop");

	cov_switch_feed: cover property (state_ff == S_WAITSW ##1
		state_ff == S_FEED && kind_ff == K_CONT);
	cov_pos_done: cover property (kind_ff == K_SWPOS && state_ff == S_FEED
		##1 state_ff == S_IDLE);
	cov_home_done: cover property (doneStb_ff && kind_ff == K_HOME);
endmodule
`default_nettype wire

/* File: core/switch_homing_defines.svh */
`ifndef SWITCH_HOMING_DEFINES_SVH
`define SWITCH_HOMING_DEFINES_SVH

// Register byte offsets
`define REG_OP_SELECT 8'h00
`define REG_COMMAND 8'h04
`define REG_MOVE_AMOUNT 8'h08
`define REG_ENV_ONE 8'h0c
`define REG_ENV_TWO 8'h10
`define REG_ENV_HOMING 8'h14
`define REG_START_SPEED 8'h18
`define REG_TOP_SPEED 8'h1c
`define REG_APPROACH_SPEED 8'h20
`define REG_SUB_STATUS 8'h24
`define REG_EXT_STATUS 8'h28
`define REG_COUNTER_ONE 8'h2c

// Commands and operation codes
`define CMD_START_BASE 6'h14
`define CMD_IMMEDIATE_STOP 8'h49
`define OP_SWITCH_CONT 7'h02
`define OP_SWITCH_POS 7'h56
`define OP_HOME_POS 7'h10
`define OP_HOME_NEG 7'h18
`define OP_LEAVE_POS 7'h12
`define OP_LEAVE_NEG 7'h1a
`define OP_SEARCH_POS 7'h15
`define OP_SEARCH_NEG 7'h1d

// Field positions
`define ENV1_LIMIT_DECEL 3
`define ENV1_ORIGIN_LOGIC 5
`define ENV1_CLEAR_AUTO 11
`define ENV1_SWITCH_LOGIC 25
`define ENV1_SENSOR_FILTER 26
`define ENV2_INDEX_EDGE 16
`define ENV3_METHOD_LSB 0
`define ENV3_INDEX_COUNT_LSB 4
`define ENV3_CLEAR_COUNTER_ONE 20
`define SUB_LIMIT_PLUS 12
`define EXT_INDEX_STATE 10
`define EXT_SWITCH_PLUS 11

// Condition codes
`define CND_IDLE 4'h0
`define CND_WAIT_SWITCH 4'h1
`define CND_RUNNING 4'h2

// Reset values
`define RST_ZERO32 32'h00000000
`define RST_START_PERIOD 16'h0064
`define RST_TOP_PERIOD 16'h000a
`define RST_APPROACH_PERIOD 16'h00c8

// Timing
`define CLK_PERIOD_NS 100
`define FILTER_TIME_NS 4000
`define CLEAR_PULSE_TIME_NS 1000

`endif

/* File: core/switch_homing_pkg.sv */
package switch_homing_pkg;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_WAITSW = 3'b001,
		S_FEED = 3'b010,
		S_BRAKE = 3'b011,
		S_BACK = 3'b100,
		S_RETURN = 3'b101
	} axis_state_e;
	typedef enum logic [1:0] {
		K_NONE = 2'b00,
		K_CONT = 2'b01,
		K_SWPOS = 2'b10,
		K_HOME = 2'b11
	} op_kind_e;
	typedef enum logic [1:0] {
		A_STOP = 2'b00,
		A_DONE = 2'b01,
		A_BACK = 2'b10
	} after_brake_e;
	typedef struct packed {
		logic origin;
		logic limitMinus;
		logic limitPlus;
	} sensor_s;
endpackage

/* File: verif/motor_side_model.sv */
`timescale 1ns/1ps
`default_nettype none
module motor_side_model #(
	parameter int ORIGIN_POS = 30
) (
	// Clock
	input wire logic core_clk,
	// Command pulses
	input wire logic pulseOut,
	input wire logic dirOut,
	// Sensors and strap
	output logic originSensor,
	output logic encoderIndex,
	output logic limitLogicStrap
);
	int position = 0;
	////////////////////////////////////////////////////////////////////////
	// One step per command pulse, dirOut high is negative
	always @(posedge core_clk) begin
		if (pulseOut) begin
			position <= dirOut ? position - 1 : position + 1;
		end
	end
	// Origin flag from a fixed spot onward, active high
	assign originSensor = (position >= ORIGIN_POS);
	// Index mark every fourth step
	assign encoderIndex = (position[1:0] == 2'h0);
	// Strap low, so limits read active high
	assign limitLogicStrap = 1'h0;
endmodule
`default_nettype wire

/* File: verif/test_switch_homing_axis.sv */
`timescale 1ns/1ps
`default_nettype none
module test_switch_homing_axis;
	logic core_clk = 1'h0;
	logic rst_n = 1'h0;
	logic [7:0] awaddr = 8'h0;
	logic [7:0] araddr = 8'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0, switchGate_n = 1'h0;
	logic jogPlusSwitch = 1'h0, jogMinusSwitch = 1'h0;
	logic endLimitPlus = 1'h0, endLimitMinus = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, pulseOut, dirOut;
	logic deviationClearOut, errorIrq, originSensor, encoderIndex;
	logic limitLogicStrap;
	logic [1:0] bresp, rresp, rr;
	logic [31:0] rdata, rd, snap;
	int n_fail = 0, tests_run = 0, pulses = 0;

	always #50 core_clk = ~core_clk;

	switch_homing_axis dut (.core_clk, .rst_n, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .jogPlusSwitch,
		.jogMinusSwitch, .switchGate_n, .endLimitPlus, .endLimitMinus,
		.originSensor, .encoderIndex, .limitLogicStrap, .pulseOut, .dirOut,
		.deviationClearOut, .errorIrq);
	motor_side_model model (.core_clk, .pulseOut, .dirOut, .originSensor,
		.encoderIndex, .limitLogicStrap);

	always @(posedge core_clk) begin
		if (pulseOut) begin
			pulses <= pulses + 1;
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge core_clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (!bvalid);
		bready <= 1'h0;
		@(posedge core_clk);
	endtask

	task automatic rdr(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge core_clk);
			if (arready) arvalid <= 1'h0;
		end while (!rvalid);
		rd = rdata;
		rr = rresp;
		rready <= 1'h0;
		@(posedge core_clk);
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Whole run needs well under two thousand cycles
	initial begin
		repeat (30000) @(posedge core_clk);
		n_fail++;
		end_sim;
	end

	initial begin
		int i;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'h1;
		@(posedge core_clk);
		rdr(8'h28);
		chk(rd & 32'hf, 32'h0);
		rdr(8'h30);
		chk({30'h0, rr}, 32'h2);
		// Switch and origin active high, auto clear; short periods
		wr(8'h0c, 32'h02000820);
		wr(8'h18, 32'h4);
		wr(8'h20, 32'h4);
		$display("Test register setup done");
		wr(8'h00, 32'h2);
		wr(8'h04, 32'h50);
		rdr(8'h28);
		chk(rd & 32'hf, 32'h1);
		jogPlusSwitch <= 1'h1;
		repeat (40) @(posedge core_clk);
		chk({31'h0, dirOut}, 32'h0);
		chk({31'h0, pulses > 0}, 32'h1);
		jogPlusSwitch <= 1'h0;
		repeat (10) @(posedge core_clk);
		snap = pulses;
		repeat (40) @(posedge core_clk);
		chk(pulses - snap, 32'h0);
		jogMinusSwitch <= 1'h1;
		repeat (40) @(posedge core_clk);
		chk({31'h0, dirOut}, 32'h1);
		jogMinusSwitch <= 1'h0;
		wr(8'h04, 32'h49);
		$display("Test gated feed done");
		// Switch chatter while the move runs must not matter
		wr(8'h08, 32'h3);
		wr(8'h00, 32'h56);
		wr(8'h04, 32'h50);
		snap = pulses;
		jogPlusSwitch <= 1'h1;
		repeat (3) begin
			repeat (3) @(posedge core_clk);
			jogPlusSwitch <= ~jogPlusSwitch;
		end
		repeat (60) @(posedge core_clk);
		chk(pulses - snap, 32'h3);
		rdr(8'h28);
		chk(rd & 32'hf, 32'h0);
		wr(8'h08, 32'h0);
		wr(8'h04, 32'h50);
		snap = pulses;
		jogPlusSwitch <= 1'h1;
		repeat (30) @(posedge core_clk);
		chk(pulses - snap, 32'h0);
		rdr(8'h28);
		chk(rd & 32'hf, 32'h0);
		jogPlusSwitch <= 1'h0;
		$display("Test switch positioning done");
		wr(8'h08, 32'h64);
		wr(8'h04, 32'h50);
		jogMinusSwitch <= 1'h1;
		repeat (20) @(posedge core_clk);
		endLimitMinus <= 1'h1;
		repeat (3) @(posedge core_clk);
		chk({31'h0, errorIrq}, 32'h1);
		rdr(8'h24);
		chk((rd >> 13) & 32'h1, 32'h1);
		snap = pulses;
		repeat (20) @(posedge core_clk);
		chk(pulses - snap, 32'h0);
		endLimitMinus <= 1'h0;
		jogMinusSwitch <= 1'h0;
		wr(8'h04, 32'h49);
		chk({31'h0, errorIrq}, 32'h0);
		endLimitPlus <= 1'h1;
		repeat (3) @(posedge core_clk);
		rdr(8'h24);
		chk((rd >> 12) & 32'h3, 32'h1);
		endLimitPlus <= 1'h0;
		$display("Test limit stop done");
		// Filter on: a limit blip shorter than 40 cycles must not show
		wr(8'h0c, 32'h06000820);
		endLimitPlus <= 1'h1;
		repeat (20) @(posedge core_clk);
		rdr(8'h24);
		chk((rd >> 12) & 32'h1, 32'h0);
		endLimitPlus <= 1'h0;
		repeat (50) @(posedge core_clk);
		endLimitPlus <= 1'h1;
		repeat (50) @(posedge core_clk);
		rdr(8'h24);
		chk((rd >> 12) & 32'h1, 32'h1);
		endLimitPlus <= 1'h0;
		repeat (50) @(posedge core_clk);
		$display("Test input filter done");
		// Method 0, positive, clear counter one on completion
		wr(8'h14, 32'h00100000);
		wr(8'h00, 32'h10);
		wr(8'h04, 32'h50);
		for (i = 0; i < 3000 && deviationClearOut !== 1'h1; i++) begin
			@(posedge core_clk);
		end
		chk({31'h0, deviationClearOut}, 32'h1);
		rdr(8'h2c);
		chk(rd, 32'h0);
		rdr(8'h24);
		chk((rd >> 14) & 32'h1, 32'h1);
		rdr(8'h28);
		chk(rd & 32'hf, 32'h0);
		chk((rd >> 10) & 32'h1, {31'h0, encoderIndex});
		$display("Test homing done");
		// Leave zero backwards, then method 1 from below the origin
		wr(8'h00, 32'h1a);
		wr(8'h04, 32'h50);
		repeat (300) @(posedge core_clk);
		rdr(8'h24);
		chk((rd >> 14) & 32'h1, 32'h0);
		wr(8'h14, 32'h00100001);
		wr(8'h00, 32'h10);
		wr(8'h04, 32'h50);
		for (i = 0; i < 3000 && deviationClearOut !== 1'h1; i++) begin
			@(posedge core_clk);
		end
		chk({31'h0, deviationClearOut}, 32'h1);
		chk({31'h0, dirOut}, 32'h0);
		rdr(8'h24);
		chk((rd >> 14) & 32'h1, 32'h1);
		rdr(8'h2c);
		chk(rd, 32'h0);
		$display("Test leave and method 1 done");
		end_sim;
	end
endmodule
`default_nettype wire
